// >>> inc/cvp_pkg.sv
// Purpose: shared constants of the configuration and status vector port
// Assumes: one core clock; register port data is 16 bits wide
// Notes:   register address is {phy address, register index}
package cvp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int PHY_W  = 5;
  localparam int IDX_W  = 5;
  localparam int ADDR_W = PHY_W + IDX_W;
  localparam int CFG_W  = 5;

  // ----------------------------------------------------------------
  // register indices within one phy address
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] REG_CTRL     = 5'h00;
  localparam logic [IDX_W-1:0] REG_ADVERT   = 5'h04;
  localparam logic [IDX_W-1:0] REG_IRQ_STAT = 5'h10;
  localparam logic [IDX_W-1:0] REG_IRQ_MASK = 5'h11;
  localparam logic [IDX_W-1:0] REG_STATUS   = 5'h12;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_CFG_LSB     = 0;
  localparam int CTRL_RESTART_BIT = 9;
  localparam logic [DATA_W-1:0] CTRL_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] ADVERT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [PHY_W-1:0]  PHY_RST    = 5'h00;

  // ----------------------------------------------------------------
  // edge detector lanes and interrupt events
  // ----------------------------------------------------------------
  localparam int NUM_EDGE  = 3;
  localparam int EDGE_CFG  = 0;
  localparam int EDGE_ADV  = 1;
  localparam int EDGE_RST  = 2;
  localparam int NUM_EV    = 4;
  localparam int EV_AN     = 0;
  localparam int EV_CFG    = 1;
  localparam int EV_ADV    = 2;
  localparam int EV_RST    = 3;
  localparam logic [NUM_EV-1:0] IRQ_MASK_RST = 4'h0;

endpackage

// >>> inc/cvp_evt_if.sv
// Purpose: carries apply and restart load pulses between port modules
// Assumes: pulses are one core clock cycle long
// Notes:   src drives, dst consumes
`timescale 1ns/10ps
interface cvp_evt_if import cvp_pkg::*; ();
  logic [NUM_EDGE-1:0] pulse;
  modport src (output pulse);
  modport dst (input  pulse);
endinterface

// >>> rtl/cvp_edge_detect.sv
// Purpose: rising edge detection on the apply and restart inputs
// Assumes: inputs are synchronous to core_clk
// Notes:   pulse is high in the cycle where the input is first seen high
`timescale 1ns/10ps
module cvp_edge_detect import cvp_pkg::*; (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic [NUM_EDGE-1:0] levelIn,
  cvp_evt_if.src                   evt
);

  logic [NUM_EDGE-1:0] prev_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // one detector per lane
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_EDGE; i++) begin : g_lane
    // remember last cycle's level
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= levelIn[i];
      end
    end
    // held level yields no second pulse
    assign evt.pulse[i] = levelIn[i] & ~prev_q[i];

    single_pulse_a : assert property (evt.pulse[i] |=> !evt.pulse[i])
      else $error("load pulse longer than one cycle");
    held_level_a : assert property ($past(levelIn[i]) && levelIn[i] |-> !evt.pulse[i])
      else $error("pulse while input held high");
  end

endmodule

// >>> rtl/cvp_irq_ctrl.sv
// Purpose: sticky event status, mask and level interrupt
// Assumes: events are one-cycle pulses from the same clock
// Notes:   a set in the clearing cycle wins over the clear
`timescale 1ns/10ps
module cvp_irq_ctrl import cvp_pkg::*; (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [NUM_EV-1:0] evtIn,
  input  wire logic              clrWr,
  input  wire logic              maskWr,
  input  wire logic [NUM_EV-1:0] wrBits,
  output logic      [NUM_EV-1:0] stat_q,
  output logic      [NUM_EV-1:0] mask_q,
  output logic                   irq_q
);

  logic [NUM_EV-1:0] stat_d;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // write-one-to-clear, events set
  assign stat_d = (stat_q & ~(clrWr ? wrBits : '0)) | evtIn;

  // sticky status
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // mask register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= IRQ_MASK_RST;
    end else if (maskWr) begin
      mask_q <= wrBits;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  set_wins_a : assert property (evtIn[EV_AN] |=> stat_q[EV_AN])
    else $error("event lost in status");
  sticky_a : assert property (stat_q[EV_AN] && !(clrWr && wrBits[EV_AN]) |=> stat_q[EV_AN])
    else $error("status bit dropped without clear");

endmodule

// >>> rtl/cvp_vector_port.sv
// Purpose: vector configuration and status port of the PCS core
// Assumes: vectors, strobes and core signals share core_clk; phyad is a pin
// Notes:   register address is {phy address, register index}
//
// Behaviour
// - a 5-bit configuration vector programs the low field of control register 0 in every build.
// - with management present, a rising edge of the configuration apply input loads that field.
// - a 16-bit advertisement vector programs register 4 in every build.
// - with management present, a rising edge of the advertisement apply input loads register 4.
// - with negotiation built in, a rising restart edge sets bit 9 of control register 0.
// - with management, negotiation completion raises a sticky, maskable, write-cleared interrupt.
// - without management, the interrupt follows negotiation complete and not restarting.
// - a 16-bit status vector continuously shows the core link and sync state.
// - all vectors are synchronous to the single core clock.
// - register accesses only take effect when their phy field matches the phy address input.
`timescale 1ns/10ps
module cvp_vector_port import cvp_pkg::*; #(
  parameter bit HAS_MGMT = 1'b1,
  parameter bit HAS_AN   = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic [PHY_W-1:0]  phyAddrPin,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [CFG_W-1:0]  cfgLoadBits,
  input  wire logic              cfgApply,
  input  wire logic [DATA_W-1:0] advertLoadBits,
  input  wire logic              advertApply,
  input  wire logic              negotiationRestartReq,
  input  wire logic              anComplete,
  input  wire logic              anRestartAck,
  input  wire logic [DATA_W-1:0] coreStatus,
  output logic      [DATA_W-1:0] ctrlReg,
  output logic      [DATA_W-1:0] advertReg,
  output logic      [DATA_W-1:0] statusVector,
  output logic                   negotiationDoneIrq,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PHY_W-1:0]  phyMeta_q;
  logic [PHY_W-1:0]  phySync_q;
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] advert_q;
  logic [DATA_W-1:0] advert_d;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdMux;
  logic              negIrq_q;
  logic              anPrev_q;
  logic              addrHit;
  logic              wrEn;
  logic [IDX_W-1:0]  regIdx;
  logic              wrCtrl;
  logic              wrAdvert;
  logic              wrStat;
  logic              wrMask;
  logic              cfgLoad;
  logic              advLoad;
  logic              restartLoad;
  logic              anRise;
  logic [NUM_EV-1:0] events;
  logic [NUM_EV-1:0] irqStat;
  logic [NUM_EV-1:0] irqMask;
  logic              irqLevel;

  cvp_evt_if evtBus ();

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // phy address pin synchroniser
  // ----------------------------------------------------------------
  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phyMeta_q <= PHY_RST;
      phySync_q <= PHY_RST;
    end else begin
      phyMeta_q <= phyAddrPin;
      phySync_q <= phyMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // access belongs to this register set only on phy match
  assign addrHit  = (regAddr[ADDR_W-1:IDX_W] == phySync_q);
  assign regIdx   = regAddr[IDX_W-1:0];
  // without management, software has no write path
  assign wrEn     = HAS_MGMT && regWrStb && addrHit;
  assign wrCtrl   = wrEn && (regIdx == REG_CTRL);
  assign wrAdvert = wrEn && (regIdx == REG_ADVERT);
  assign wrStat   = wrEn && (regIdx == REG_IRQ_STAT);
  assign wrMask   = wrEn && (regIdx == REG_IRQ_MASK);

  // ----------------------------------------------------------------
  // edge detection of apply and restart inputs
  // ----------------------------------------------------------------
  cvp_edge_detect u_edge (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .levelIn  ({negotiationRestartReq, advertApply, cfgApply}),
    .evt      (evtBus.src)
  );

  // load pulses; a held level gives only one
  assign cfgLoad     = HAS_MGMT && evtBus.pulse[EDGE_CFG];
  assign advLoad     = HAS_MGMT && evtBus.pulse[EDGE_ADV];
  assign restartLoad = HAS_AN && evtBus.pulse[EDGE_RST];

  // ----------------------------------------------------------------
  // control register 0
  // ----------------------------------------------------------------
  // later assignments win: ack, write, vector load, restart set
  always_comb begin
    ctrl_d = ctrl_q;
    if (anRestartAck) begin
      ctrl_d[CTRL_RESTART_BIT] = 1'b0;
    end
    if (wrCtrl) begin
      ctrl_d = regWrData;
    end
    // vector overwrites any management value
    if (!HAS_MGMT || cfgLoad) begin
      ctrl_d[CTRL_CFG_LSB +: CFG_W] = cfgLoadBits;
    end
    if (!HAS_AN) begin
      ctrl_d[CTRL_RESTART_BIT] = 1'b0;
    end else if (restartLoad) begin
      ctrl_d[CTRL_RESTART_BIT] = 1'b1;
    end
  end

  // control register state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // advertisement register 4
  // ----------------------------------------------------------------
  // vector load wins over a management write in the same cycle
  always_comb begin
    advert_d = advert_q;
    if (wrAdvert) begin
      advert_d = regWrData;
    end
    if (!HAS_MGMT || advLoad) begin
      advert_d = advertLoadBits;
    end
  end

  // advertisement state
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      advert_q <= ADVERT_RST;
    end else begin
      advert_q <= advert_d;
    end
  end

  // ----------------------------------------------------------------
  // status vector
  // ----------------------------------------------------------------
  // same-clock core state, registered once
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= coreStatus;
    end
  end

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  // completion edge of negotiation
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      anPrev_q <= 1'b0;
    end else begin
      anPrev_q <= anComplete;
    end
  end

  assign anRise = HAS_AN && anComplete && !anPrev_q;

  // event lanes of the status register
  always_comb begin
    events         = '0;
    events[EV_AN]  = anRise;
    events[EV_CFG] = cfgLoad;
    events[EV_ADV] = advLoad;
    events[EV_RST] = restartLoad;
  end

  cvp_irq_ctrl u_irq (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .evtIn    (events),
    .clrWr    (wrStat),
    .maskWr   (wrMask),
    .wrBits   (regWrData[NUM_EV-1:0]),
    .stat_q   (irqStat),
    .mask_q   (irqMask),
    .irq_q    (irqLevel)
  );

  // negotiation interrupt: sticky with management, plain level without
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      negIrq_q <= 1'b0;
    end else if (HAS_MGMT) begin
      negIrq_q <= irqStat[EV_AN] && irqMask[EV_AN];
    end else begin
      negIrq_q <= HAS_AN && anComplete && !ctrl_q[CTRL_RESTART_BIT];
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // read mux, unmapped index reads zero
  always_comb begin
    rdMux = '0;
    case (regIdx)
      REG_CTRL: begin
        rdMux = ctrl_q;
      end
      REG_ADVERT: begin
        rdMux = advert_q;
      end
      REG_IRQ_STAT: begin
        rdMux[NUM_EV-1:0] = irqStat;
      end
      REG_IRQ_MASK: begin
        rdMux[NUM_EV-1:0] = irqMask;
      end
      REG_STATUS: begin
        rdMux = status_q;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_q <= '0;
    end else if (regRdStb && addrHit) begin
      rdData_q <= rdMux;
    end else begin
      rdData_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData          = rdData_q;
  assign ctrlReg            = ctrl_q;
  assign advertReg          = advert_q;
  assign statusVector       = status_q;
  assign negotiationDoneIrq = negIrq_q;
  assign irq                = irqLevel;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  cfg_follow_a : assert property (!HAS_MGMT |=> ctrl_q[CTRL_CFG_LSB +: CFG_W] == $past(cfgLoadBits))
    else $error("control field does not follow vector");

  cfg_load_a : assert property (cfgLoad |=> ctrl_q[CTRL_CFG_LSB +: CFG_W] == $past(cfgLoadBits))
    else $error("control field not loaded on apply edge");

  cfg_held_a : assert property (HAS_MGMT && !cfgLoad && !wrCtrl
    |=> ctrl_q[CTRL_CFG_LSB +: CFG_W] == $past(ctrl_q[CTRL_CFG_LSB +: CFG_W]))
    else $error("control field changed without load");

  adv_follow_a : assert property (!HAS_MGMT |=> advert_q == $past(advertLoadBits))
    else $error("advertisement does not follow vector");

  adv_load_a : assert property (advLoad |=> advert_q == $past(advertLoadBits))
    else $error("advertisement not loaded on apply edge");

  adv_held_a : assert property (HAS_MGMT && !advLoad && !wrAdvert |=> $stable(advert_q))
    else $error("advertisement changed without load");

  restart_set_a : assert property (restartLoad |=> ctrl_q[CTRL_RESTART_BIT])
    else $error("restart bit not set on restart edge");

  no_an_a : assert property (!HAS_AN || (!restartLoad && !wrCtrl && !ctrl_q[CTRL_RESTART_BIT])
    |=> !ctrl_q[CTRL_RESTART_BIT])
    else $error("restart bit set without restart edge");

  irq_mgmt_a : assert property (HAS_MGMT && anRise ##1 irqMask[EV_AN] |=> negIrq_q)
    else $error("enabled negotiation interrupt not raised");

  irq_plain_a : assert property (!HAS_MGMT
    |=> negIrq_q == $past(HAS_AN && anComplete && !ctrl_q[CTRL_RESTART_BIT]))
    else $error("plain negotiation level wrong");

  status_pass_a : assert property (##1 statusVector == $past(coreStatus))
    else $error("status vector lags core state");

  phy_miss_a : assert property (regWrStb && !addrHit && regIdx == REG_ADVERT && !advLoad && HAS_MGMT
    |=> $stable(advert_q))
    else $error("write taken for another phy address");

  read_once_a : assert property (regRdStb && addrHit && regIdx == REG_STATUS
    |=> regRdData == $past(status_q) ##1 ($past(regRdStb && addrHit) || regRdData == '0))
    else $error("read data wrong or held too long");

  cfg_apply_c : cover property (cfgLoad ##1 wrCtrl);
  restart_c   : cover property (restartLoad ##[1:20] anRestartAck);
  an_irq_c    : cover property (anRise ##[1:20] (wrStat && regWrData[EV_AN]));

endmodule

// >>> testbench/cvp_user_fabric.sv
// Purpose: user fabric model driving the configuration and advertisement vectors
// Assumes: commands come from the bench one cycle long, synchronous to core_clk
// Notes:   kind 0 cfg load, 1 advert load, 2 restart, 3 vectors change with no edge
`timescale 1ns/10ps
module cvp_user_fabric import cvp_pkg::*; (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              cmdValid,
  input  wire logic [1:0]        cmdKind,
  input  wire logic [DATA_W-1:0] cmdData,
  output logic                   busy,
  output logic      [CFG_W-1:0]  cfgLoadBits,
  output logic                   cfgApply,
  output logic      [DATA_W-1:0] advertLoadBits,
  output logic                   advertApply,
  output logic                   negotiationRestartReq
);
  // ----------------------------------------------------------------
  // strobe sequencing
  // ----------------------------------------------------------------
  logic [1:0] kind_q;
  logic       phase_q;

  assign busy = phase_q;

  // a load drops its strobe one cycle, then raises it again and holds it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {cfgApply, advertApply, negotiationRestartReq, phase_q} <= 4'h0;
      cfgLoadBits    <= 5'h00;
      advertLoadBits <= 16'h0000;
      kind_q         <= 2'h0;
    end else if (cmdValid) begin
      kind_q  <= cmdKind;
      phase_q <= (cmdKind != 2'h3);
      case (cmdKind)
        2'h0: begin
          cfgApply    <= 1'b0;
          cfgLoadBits <= cmdData[4:0];
        end
        2'h1: begin
          advertApply    <= 1'b0;
          advertLoadBits <= cmdData;
        end
        2'h2: negotiationRestartReq <= 1'b0;
        default: begin
          cfgLoadBits    <= cmdData[4:0];
          advertLoadBits <= cmdData;
        end
      endcase
    end else if (phase_q) begin
      phase_q <= 1'b0;
      cfgApply              <= cfgApply | (kind_q == 2'h0);
      advertApply           <= advertApply | (kind_q == 2'h1);
      negotiationRestartReq <= negotiationRestartReq | (kind_q == 2'h2);
    end
  end
endmodule

// >>> testbench/pcs_config_status_vector_port_tb.sv
// Purpose: self-checking bench of the vector port against a behavioural model
// Assumes: core_clk 20 MHz, reset held 6 cycles
// Notes:   a second instance without management checks the vector-only build
`timescale 1ns/10ps
module pcs_config_status_vector_port_tb import cvp_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, sys_rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
  logic anComplete = 1'b0, anRestartAck = 1'b0, cmdValid = 1'b0, busy;
  logic [4:0] phyAddrPin = 5'h0b, cfgLoadBits;
  logic [9:0] regAddr = 10'h000;
  logic [1:0] cmdKind = 2'h0;
  logic [15:0] regWrData = 16'h0000, coreStatus = 16'h0000, cmdData = 16'h0000, advertLoadBits;
  logic cfgApply, advertApply, negotiationRestartReq, irq, negotiationDoneIrq, nmIrq;
  logic [15:0] regRdData, ctrlReg, advertReg, statusVector, nmCtrl, nmAdv;
  int n_fail = 0, check_count = 0, expCtrl = 0, expAdv = 0, expStat = 0, expMask = 0;
  int lastCfg = 0, lastAdv = 0;
  logic [31:0] seed = 32'ha8d9_b28f;

  // free running clock
  always #25 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  cvp_user_fabric fab_u (.core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdKind(cmdKind),
    .cmdData(cmdData), .busy(busy), .cfgLoadBits(cfgLoadBits), .cfgApply(cfgApply),
    .advertLoadBits(advertLoadBits), .advertApply(advertApply), .negotiationRestartReq(negotiationRestartReq));
  cvp_vector_port dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .phyAddrPin(phyAddrPin), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .cfgLoadBits(cfgLoadBits), .cfgApply(cfgApply), .advertLoadBits(advertLoadBits),
    .advertApply(advertApply), .negotiationRestartReq(negotiationRestartReq), .anComplete(anComplete),
    .anRestartAck(anRestartAck), .coreStatus(coreStatus), .ctrlReg(ctrlReg), .advertReg(advertReg),
    .statusVector(statusVector), .negotiationDoneIrq(negotiationDoneIrq), .irq(irq));
  cvp_vector_port #(.HAS_MGMT(1'b0)) nm_u (.core_clk(core_clk), .sys_rst(sys_rst), .phyAddrPin(phyAddrPin),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(),
    .cfgLoadBits(cfgLoadBits), .cfgApply(cfgApply), .advertLoadBits(advertLoadBits),
    .advertApply(advertApply), .negotiationRestartReq(negotiationRestartReq), .anComplete(anComplete),
    .anRestartAck(anRestartAck), .coreStatus(coreStatus), .ctrlReg(nmCtrl), .advertReg(nmAdv),
    .statusVector(), .negotiationDoneIrq(nmIrq), .irq());

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one-cycle write; the model follows only when the phy field matches
  task automatic wr(input logic [4:0] idx, input logic [4:0] phy, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= {phy, idx};
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    if (phy == phyAddrPin) begin
      if (idx == REG_CTRL) expCtrl = d;
      if (idx == REG_ADVERT) expAdv = d;
      if (idx == REG_IRQ_STAT) expStat = expStat & ~int'(d[3:0]);
      if (idx == REG_IRQ_MASK) expMask = d[3:0];
    end
  endtask

  // data stand only in the cycle after the strobe, then fall to zero
  task automatic rd(input logic [4:0] idx, input logic [4:0] phy, input logic [15:0] exp);
    @(posedge core_clk);
    regAddr <= {phy, idx};
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, exp);
    @(posedge core_clk);
    #1 chk(regRdData, 16'h0000);
  endtask

  task automatic cmd(input logic [1:0] k, input logic [15:0] d);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdKind <= k;
    cmdData <= d;
    @(posedge core_clk);
    cmdValid <= 1'b0;
    if (k != 2'h1 && k != 2'h2) lastCfg = d[4:0];
    if (k == 2'h1 || k == 2'h3) lastAdv = d;
    if (k == 2'h0) expCtrl = (expCtrl & 16'hffe0) | d[4:0];
    if (k == 2'h1) expAdv = d;
    if (k == 2'h2) expCtrl = expCtrl | 16'h0200;
    if (k < 2'h3) expStat = expStat | (2 << k);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
    chk(ctrlReg, expCtrl);
    chk(advertReg, expAdv);
    chk(irq, |(expStat & expMask));
    chk(negotiationDoneIrq, expStat[0] & expMask[0]);
    chk(nmCtrl[4:0], lastCfg);
    chk(nmAdv, lastAdv);
    chk(nmIrq, anComplete & ~expCtrl[9]);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    coreStatus <= xs();
    repeat (4) @(posedge core_clk);
    settle();
    chk(statusVector, coreStatus);
    rd(REG_STATUS, phyAddrPin, coreStatus);
    rd(5'h1f, phyAddrPin, 16'h0000);
    rd(REG_STATUS, phyAddrPin ^ 5'h01, 16'h0000);
    wr(REG_ADVERT, phyAddrPin, xs());
    wr(REG_ADVERT, phyAddrPin ^ 5'h10, xs());
    settle();
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, phyAddrPin, xs() & 16'hfdff);
      coreStatus <= xs();
      cmd(2'h0, xs());
      settle();
      cmd(2'h1, xs());
      settle();
      cmd(2'h3, xs());
      settle();
      rd(REG_STATUS, phyAddrPin, coreStatus);
      rd(REG_IRQ_STAT, phyAddrPin, expStat);
      wr(REG_IRQ_STAT, phyAddrPin, 16'h000f);
    end
    wr(REG_IRQ_MASK, phyAddrPin, 16'h000f);
    rd(REG_IRQ_MASK, phyAddrPin, 16'h000f);
    cmd(2'h2, 16'h0000);
    settle();
    @(posedge core_clk);
    anRestartAck <= 1'b1;
    @(posedge core_clk);
    anRestartAck <= 1'b0;
    expCtrl = expCtrl & 16'hfdff;
    wr(REG_IRQ_STAT, phyAddrPin, 16'h0008);
    settle();
    @(posedge core_clk);
    anComplete <= 1'b1;
    expStat = expStat | 1;
    settle();
    wr(REG_IRQ_MASK, phyAddrPin, 16'h000e);
    settle();
    wr(REG_IRQ_MASK, phyAddrPin, 16'h000f);
    wr(REG_IRQ_STAT, phyAddrPin, 16'h0001);
    settle();
    cmd(2'h2, 16'h0000);
    settle();
    close_out();
  end
endmodule
